// File: rtl/reset_supervisor_windowed_watchdog.sv
// Reset supervisor with windowed watchdog and power-good reporting
`timescale 1ns/10ps
`include "supervisor_defs.svh"
module reset_supervisor_windowed_watchdog #(
    parameter logic [31:0] RST_OPEN_CYC = `RST_OPEN_CYC,
    parameter logic [31:0] RST_PUMP_CYC = `RST_PUMP_CYC,
    parameter logic [31:0] RST_CAP_CYC = `RST_CAP_CYC,
    parameter logic [31:0] WD_INT_TICK_CYC = `WD_INT_TICK_CYC,
    parameter logic [31:0] WD_CAP_TICK_CYC = `WD_CAP_TICK_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Comparator results
    input wire logic reset_sense_in,
    input wire logic pump_regulating,
    input wire logic uvlo_active,
    input wire logic low_rail_in_window,
    input wire logic high_rail_in_window,
    // Rail enables
    input wire logic enable_low_rail,
    input wire logic enable_high_rail,
    // Timing straps
    input wire logic [1:0] reset_timing_pin,
    input wire logic [1:0] wd_timing_pin,
    // Watchdog kick
    input wire logic wd_kick_in,
    // Open-drain system reset
    input wire logic sys_rst_b_pad,
    output logic sys_rst_b_drv,
    output logic sys_rst_b_oe,
    // Open-drain power-good pins
    input wire logic good_low_rail_pad,
    output logic good_low_rail_drv,
    output logic good_low_rail_oe,
    input wire logic good_high_rail_pad,
    output logic good_high_rail_drv,
    output logic good_high_rail_oe,
    // Status
    output logic wd_trip_pulse
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe_ff;
    logic rst_sync_b;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_ff <= 2'b00;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe_ff[1];

    // ----------------------------------------------------------------
    // Input synchronisation and filtering
    // ----------------------------------------------------------------
    logic [`SYNC_W-1:0] async_bus;
    logic [`SYNC_W-1:0] sync_bus;
    logic sense_s;
    logic pump_s;
    logic uvlo_s;
    logic low_win_s;
    logic high_win_s;
    logic en_low_s;
    logic en_high_s;
    logic kick_s;
    supervisor_pkg::rt_mode_t rt_mode;
    supervisor_pkg::wt_mode_t wt_mode;
    logic fault_raw;
    logic fault_f;

    assign async_bus = {wd_timing_pin, reset_timing_pin, wd_kick_in, enable_high_rail, enable_low_rail,
                        high_rail_in_window, low_rail_in_window, uvlo_active, pump_regulating, reset_sense_in};

    sync_2ff #(
        .WIDTH(`SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_sync_b),
        .ce(ce),
        .async_lvl(async_bus),
        .sync_lvl(sync_bus)
    ); // [R20]

    assign sense_s = sync_bus[0];
    assign pump_s = sync_bus[1];
    assign uvlo_s = sync_bus[2];
    assign low_win_s = sync_bus[3];
    assign high_win_s = sync_bus[4];
    assign en_low_s = sync_bus[5];
    assign en_high_s = sync_bus[6];
    assign kick_s = sync_bus[7];
    assign rt_mode = supervisor_pkg::rt_mode_t'(sync_bus[9:8]);
    assign wt_mode = supervisor_pkg::wt_mode_t'(sync_bus[11:10]);

    // Sense below threshold or pump out of regulation
    assign fault_raw = !sense_s || !pump_s; // [R01]

    // Starts as a fault so reset is held until the filter has seen good levels
    glitch_filter #(
        .CYCLES(`GLITCH_CYC),
        .RESET_VAL(1'b1)
    ) u_fault_filter (
        .ref_clk(ref_clk),
        .rst_b(rst_sync_b),
        .ce(ce),
        .raw_lvl(fault_raw),
        .clean_lvl(fault_f)
    ); // [R05]

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic [31:0] to_limit;
    logic [31:0] tick_limit;
    logic [`WD_CNT_W-1:0] wd_lower;
    logic [`WD_CNT_W-1:0] wd_upper;
    logic wd_en;

    always_comb begin
        case (rt_mode)
            supervisor_pkg::RT_OPEN: to_limit = RST_OPEN_CYC; // [R04]
            supervisor_pkg::RT_PUMP: to_limit = RST_PUMP_CYC; // [R04]
            supervisor_pkg::RT_CAP: to_limit = RST_CAP_CYC; // [R04]
            default: to_limit = RST_OPEN_CYC;
        endcase
    end

    always_comb begin
        case (wt_mode)
            supervisor_pkg::WT_CAP: begin
                tick_limit = WD_CAP_TICK_CYC;
                wd_lower = `WD_CNT_W'(`WD_CAP_LOWER); // [R14]
                wd_upper = `WD_CNT_W'(`WD_CAP_UPPER); // [R13]
                wd_en = 1'b1;
            end
            supervisor_pkg::WT_BIAS: begin
                tick_limit = WD_INT_TICK_CYC; // [R16]
                wd_lower = `WD_CNT_W'(`WD_INT_LOWER); // [R15]
                wd_upper = `WD_CNT_W'(`WD_INT_UPPER); // [R11] [R12]
                wd_en = 1'b1;
            end
            default: begin
                // Grounded or unknown strap: no watchdog
                tick_limit = WD_INT_TICK_CYC;
                wd_lower = `WD_CNT_W'(`WD_INT_LOWER);
                wd_upper = `WD_CNT_W'(`WD_INT_UPPER);
                wd_en = 1'b0; // [R17]
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Supervisor state machine and watchdog
    // ----------------------------------------------------------------
    supervisor_pkg::sup_reg_t cur_ff;
    supervisor_pkg::sup_reg_t nxt_ff;
    logic kick_fall;
    logic kick_early;
    logic kick_good;
    logic wd_late;
    logic wd_tick;
    logic pg_off;

    assign kick_fall = cur_ff.kick_prev && !kick_s;
    assign kick_early = wd_en && kick_fall && (cur_ff.wd_cnt < wd_lower); // [R08]
    assign kick_good = wd_en && kick_fall && !kick_early; // [R07]
    assign wd_late = wd_en && (cur_ff.wd_cnt >= wd_upper); // [R08]
    assign wd_tick = (cur_ff.tick_cnt == tick_limit - 32'd1);
    assign pg_off = (!en_low_s && !en_high_s) || uvlo_s; // [R18]

    always_comb begin
        nxt_ff = cur_ff;
        if (ce) begin
            nxt_ff.kick_prev = kick_s;
            nxt_ff.wd_trip = 1'b0;
            if (uvlo_s) begin
                // Lockout overrides everything and keeps the timer idle
                nxt_ff.state = supervisor_pkg::ST_UVLO; // [R06]
                nxt_ff.to_cnt = '0;
            end else if (fault_f) begin
                nxt_ff.state = supervisor_pkg::ST_HOLD; // [R01]
                nxt_ff.to_cnt = '0;
            end else begin
                case (cur_ff.state)
                    supervisor_pkg::ST_UVLO: begin
                        nxt_ff.state = supervisor_pkg::ST_TIMEOUT;
                        nxt_ff.to_cnt = '0;
                    end
                    supervisor_pkg::ST_HOLD: begin
                        nxt_ff.state = supervisor_pkg::ST_TIMEOUT; // [R02]
                        nxt_ff.to_cnt = '0;
                    end
                    supervisor_pkg::ST_TIMEOUT: begin
                        if (cur_ff.to_cnt == to_limit - 32'd1) begin
                            nxt_ff.state = supervisor_pkg::ST_RUN; // [R02] [R09]
                            nxt_ff.to_cnt = '0;
                        end else begin
                            nxt_ff.to_cnt = cur_ff.to_cnt + 32'd1;
                        end
                    end
                    supervisor_pkg::ST_RUN: begin
                        if (kick_early || wd_late) begin
                            nxt_ff.state = supervisor_pkg::ST_TIMEOUT; // [R08]
                            nxt_ff.to_cnt = '0;
                            nxt_ff.wd_trip = 1'b1;
                        end
                    end
                    default: begin
                        nxt_ff.state = supervisor_pkg::ST_HOLD;
                        nxt_ff.to_cnt = '0;
                    end
                endcase
            end

            // Watchdog only counts while reset is released
            if (nxt_ff.state != supervisor_pkg::ST_RUN || cur_ff.state != supervisor_pkg::ST_RUN || !wd_en) begin
                nxt_ff.wd_cnt = '0; // [R10] [R09] [R17]
                nxt_ff.tick_cnt = '0;
            end else if (kick_good) begin
                nxt_ff.wd_cnt = '0; // [R21]
                nxt_ff.tick_cnt = '0;
            end else if (wd_tick) begin
                nxt_ff.tick_cnt = '0;
                nxt_ff.wd_cnt = cur_ff.wd_cnt + `WD_CNT_W'(1);
            end else begin
                nxt_ff.tick_cnt = cur_ff.tick_cnt + 32'd1;
            end

            nxt_ff.rst_drive = (nxt_ff.state != supervisor_pkg::ST_RUN);
            nxt_ff.pg_low_drive = pg_off || !low_win_s; // [R18] [R19]
            nxt_ff.pg_high_drive = pg_off || !high_win_s; // [R18] [R19]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur_ff <= '{state: supervisor_pkg::ST_HOLD, to_cnt: '0, tick_cnt: '0, wd_cnt: '0,
                        kick_prev: 1'b0, rst_drive: 1'b1, pg_low_drive: 1'b1, pg_high_drive: 1'b1,
                        wd_trip: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    // Open drain: only ever pulls low, release is high impedance
    assign sys_rst_b_drv = 1'b0; // [R03]
    assign sys_rst_b_oe = cur_ff.rst_drive; // [R03]
    assign good_low_rail_drv = 1'b0;
    assign good_low_rail_oe = cur_ff.pg_low_drive;
    assign good_high_rail_drv = 1'b0;
    assign good_high_rail_oe = cur_ff.pg_high_drive;
    assign wd_trip_pulse = cur_ff.wd_trip;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_clear_run;
        ce && !uvlo_s && !fault_f && cur_ff.state == supervisor_pkg::ST_RUN;
    endsequence

    sequence s_timeout_end;
        ce && !uvlo_s && !fault_f && cur_ff.state == supervisor_pkg::ST_TIMEOUT &&
            cur_ff.to_cnt == to_limit - 32'd1;
    endsequence

    property p_fault_pulls_reset;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            ce && fault_f && !uvlo_s |=> sys_rst_b_oe && cur_ff.state == supervisor_pkg::ST_HOLD;
    endproperty
    a_fault_pulls_reset: assert property (p_fault_pulls_reset) else $error("fault did not pull reset"); // [R01]

    property p_hold_for_timeout;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            ce && cur_ff.state == supervisor_pkg::ST_TIMEOUT && cur_ff.to_cnt != to_limit - 32'd1
            |=> sys_rst_b_oe;
    endproperty
    a_hold_for_timeout: assert property (p_hold_for_timeout) else $error("reset released early"); // [R02]

    property p_release_at_end;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            s_timeout_end |=> !sys_rst_b_oe && !sys_rst_b_drv && cur_ff.wd_cnt == '0;
    endproperty
    a_release_at_end: assert property (p_release_at_end) else $error("reset not released at timeout end"); // [R03]

    property p_uvlo_holds;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            ce && uvlo_s |=> sys_rst_b_oe && cur_ff.to_cnt == '0;
    endproperty
    a_uvlo_holds: assert property (p_uvlo_holds) else $error("lockout did not hold reset"); // [R06]

    property p_early_kick;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            s_clear_run ##0 (wd_en && kick_fall && cur_ff.wd_cnt < wd_lower)
            |=> sys_rst_b_oe && wd_trip_pulse ##1 !wd_trip_pulse;
    endproperty
    a_early_kick: assert property (p_early_kick) else $error("early kick did not trip"); // [R08]

    property p_late_trip;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            s_clear_run ##0 (wd_en && cur_ff.wd_cnt == wd_upper) |=> cur_ff.state == supervisor_pkg::ST_TIMEOUT;
    endproperty
    a_late_trip: assert property (p_late_trip) else $error("missing kick did not trip"); // [R08] [R12]

    property p_wd_cleared;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            sys_rst_b_oe |-> cur_ff.wd_cnt == '0 && cur_ff.tick_cnt == '0;
    endproperty
    a_wd_cleared: assert property (p_wd_cleared) else $error("watchdog ran during reset"); // [R10]

    property p_good_kick;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            s_clear_run ##0 (kick_fall && wd_en && cur_ff.wd_cnt >= wd_lower && cur_ff.wd_cnt < wd_upper)
            |=> cur_ff.wd_cnt == '0 && !sys_rst_b_oe;
    endproperty
    a_good_kick: assert property (p_good_kick) else $error("good kick did not restart watchdog"); // [R21]

    property p_window_bounds;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            wt_mode == supervisor_pkg::WT_CAP |-> wd_upper == `WD_CNT_W'(128) && wd_lower == `WD_CNT_W'(5);
    endproperty
    a_window_bounds: assert property (p_window_bounds) else $error("capacitor window wrong"); // [R13] [R14]

    property p_int_bounds;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            wt_mode == supervisor_pkg::WT_BIAS |-> wd_upper == `WD_CNT_W'(8192) && wd_lower == `WD_CNT_W'(256);
    endproperty
    a_int_bounds: assert property (p_int_bounds) else $error("internal window wrong"); // [R11] [R15]

    property p_wd_disabled;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            ce && wt_mode == supervisor_pkg::WT_GND |=> !wd_trip_pulse;
    endproperty
    a_wd_disabled: assert property (p_wd_disabled) else $error("disabled watchdog tripped"); // [R17]

    property p_pg_shutdown;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            ce && pg_off |=> good_low_rail_oe && good_high_rail_oe;
    endproperty
    a_pg_shutdown: assert property (p_pg_shutdown) else $error("power-good not pulled in shutdown"); // [R18]

    property p_pg_window;
        @(posedge ref_clk) disable iff (!rst_sync_b)
            ce && !pg_off |=> good_low_rail_oe == !$past(low_win_s) && good_high_rail_oe == !$past(high_win_s);
    endproperty
    a_pg_window: assert property (p_pg_window) else $error("power-good does not follow window"); // [R19]

endmodule // reset_supervisor_windowed_watchdog

// File: rtl/supervisor_defs.svh
// Constants for the reset supervisor and windowed watchdog
//
// Summary of operation
// [R01] Drive reset low on sense low or pump unregulated
// [R02] Hold reset one timeout after conditions clear
// [R03] Release reset as high impedance, never driven high
// [R04] Timing pin picks 0.75ms, 0.2s or capacitor
// [R05] Filter short glitches on the reset conditions
// [R06] Undervoltage lockout holds reset, ignores others, no timeout
// [R07] Host spaces kick falling edges inside window
// [R08] Early or missing kick starts a reset timeout
// [R09] After watchdog timeout, release and restart from zero
// [R10] Watchdog cleared while reset asserted, runs once released
// [R11] Internal mode watchdog period is 8193 clocks
// [R12] Upper bound one watchdog clock before period end
// [R13] Capacitor mode period 129 clocks, upper 128
// [R14] Capacitor mode lower bound at five clocks
// [R15] Internal mode lower bound is period over 32
// [R16] Timing pin at bias gives about 1.6s period
// [R17] Timing pin grounded disables the watchdog entirely
// [R18] Both enables low or lockout pulls power-good low
// [R19] Power-good released inside window, pulled low outside
// [R20] Comparator results enter as synchronised single bits
// [R21] Kick inside the window restarts watchdog from zero
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// ----------------------------------------------------------------
// Clock and filter timing
// ----------------------------------------------------------------
`define REF_CLK_KHZ 125000
`define REF_CLK_PERIOD_NS 8
`define GLITCH_NS 96
`define GLITCH_CYC ((`GLITCH_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Reset timeout lengths
// ----------------------------------------------------------------
`define RST_OPEN_US 750
`define RST_PUMP_MS 200
`define RST_CAP_MS 32
`define RST_OPEN_CYC ((`RST_OPEN_US * `REF_CLK_KHZ) / 1000)
`define RST_PUMP_CYC (`RST_PUMP_MS * `REF_CLK_KHZ)
`define RST_CAP_CYC (`RST_CAP_MS * `REF_CLK_KHZ)

// ----------------------------------------------------------------
// Watchdog periods and window, in watchdog clocks
// ----------------------------------------------------------------
`define WD_BIAS_MS 1600
`define WD_CAP_MS 5300
`define WD_INT_PERIOD 8193
`define WD_INT_UPPER (`WD_INT_PERIOD - 1)
`define WD_INT_LOWER (`WD_INT_PERIOD / 32)
`define WD_CAP_PERIOD 129
`define WD_CAP_UPPER (`WD_CAP_PERIOD - 1)
`define WD_CAP_LOWER 5
`define WD_INT_TICK_CYC ((`WD_BIAS_MS * `REF_CLK_KHZ) / `WD_INT_PERIOD)
`define WD_CAP_TICK_CYC ((`WD_CAP_MS * `REF_CLK_KHZ) / `WD_CAP_PERIOD)

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SYNC_W 12
`define WD_CNT_W 14

`endif

// File: rtl/supervisor_pkg.sv
// Types shared by the supervisor design
package supervisor_pkg;

    typedef enum logic [1:0] {
        ST_UVLO = 2'b00,
        ST_HOLD = 2'b01,
        ST_TIMEOUT = 2'b10,
        ST_RUN = 2'b11
    } sup_state_t;

    typedef enum logic [1:0] {
        RT_OPEN = 2'b00,
        RT_PUMP = 2'b01,
        RT_CAP = 2'b10
    } rt_mode_t;

    typedef enum logic [1:0] {
        WT_GND = 2'b00,
        WT_BIAS = 2'b01,
        WT_CAP = 2'b10
    } wt_mode_t;

    typedef struct packed {
        sup_state_t state;
        logic [31:0] to_cnt;
        logic [31:0] tick_cnt;
        logic [13:0] wd_cnt;
        logic kick_prev;
        logic rst_drive;
        logic pg_low_drive;
        logic pg_high_drive;
        logic wd_trip;
    } sup_reg_t;

endpackage

// File: rtl/sync_2ff.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Levels
    input wire logic [WIDTH-1:0] async_lvl,
    output logic [WIDTH-1:0] sync_lvl
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_reg_t;

    sync_reg_t cur_ff;
    sync_reg_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        if (ce) begin
            nxt_ff.s1 = async_lvl;
            nxt_ff.s2 = cur_ff.s1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign sync_lvl = cur_ff.s2;
endmodule // sync_2ff

// File: rtl/glitch_filter.sv
// Level filter: output follows input only after it stands for CYCLES clocks
`timescale 1ns/10ps
module glitch_filter #(
    parameter int CYCLES = 4,
    parameter bit RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Level
    input wire logic raw_lvl,
    output logic clean_lvl
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic out;
        logic [CW-1:0] cnt;
    } filt_reg_t;

    filt_reg_t cur_ff;
    filt_reg_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        if (ce) begin
            if (raw_lvl == cur_ff.out) begin
                nxt_ff.cnt = '0;
            end else if (cur_ff.cnt == CW'(CYCLES - 1)) begin
                nxt_ff.out = raw_lvl;
                nxt_ff.cnt = '0;
            end else begin
                nxt_ff.cnt = cur_ff.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '{out: RESET_VAL, cnt: '0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign clean_lvl = cur_ff.out;
endmodule // glitch_filter

// File: tb/kick_host.sv
// Host processor model that kicks the watchdog at a fixed spacing
`timescale 1ns/10ps
module kick_host (
    // Clock and the wired reset line it sits behind
    input wire logic ref_clk,
    input wire logic rst_line,
    // Spacing of falling edges in clocks, zero for a hung host
    input wire logic [15:0] gap_cyc,
    // Kick output, push-pull
    output logic wd_kick_in
);
    logic [15:0] cnt_ff = 16'h0;
    logic [15:0] nxt_cnt;
    logic kick_ff = 1'b1;
    assign nxt_cnt = (cnt_ff == gap_cyc - 16'h1) ? 16'h0 : cnt_ff + 16'h1;
    assign wd_kick_in = kick_ff;
    // Host restarts with the reset line, as a real processor would
    always @(negedge ref_clk) begin
        if (!rst_line || gap_cyc == 16'h0) begin
            cnt_ff <= 16'h0;
            kick_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            // Short low pulse at wrap: first fall a full gap after release
            kick_ff <= (nxt_cnt != 16'h0);
        end
    end
endmodule // kick_host

// File: tb/test_reset_supervisor_windowed_watchdog.sv
// Self-checking bench for the reset supervisor and watchdog
`timescale 1ns/10ps
module test_reset_supervisor_windowed_watchdog;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic sense = 1'b0, pump = 1'b1, uvlo = 1'b0;
    logic win_lo = 1'b1, win_hi = 1'b1, en_lo = 1'b1, en_hi = 1'b1;
    logic [1:0] rt = 2'h0, wt = 2'h0;
    logic [15:0] gap = 16'h0;
    logic kick;
    wire oe, drv, lo_oe, lo_drv, hi_oe, hi_drv, trip;
    // Pull-ups on the open-drain pins
    wire rst_line = oe ? drv : 1'b1;
    wire lo_pad = lo_oe ? lo_drv : 1'b1;
    wire hi_pad = hi_oe ? hi_drv : 1'b1;
    int errors = 0, checks = 0, trips = 0, t0, n;
    int lims[3] = '{20, 30, 40};

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (trip === 1'b1) trips <= trips + 1;

    reset_supervisor_windowed_watchdog #(
        .RST_OPEN_CYC(32'h14), .RST_PUMP_CYC(32'h1e), .RST_CAP_CYC(32'h28),
        .WD_INT_TICK_CYC(32'h2), .WD_CAP_TICK_CYC(32'h3)
    ) u_reset_supervisor_windowed_watchdog (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
        .reset_sense_in(sense), .pump_regulating(pump), .uvlo_active(uvlo),
        .low_rail_in_window(win_lo), .high_rail_in_window(win_hi),
        .enable_low_rail(en_lo), .enable_high_rail(en_hi),
        .reset_timing_pin(rt), .wd_timing_pin(wt), .wd_kick_in(kick),
        .sys_rst_b_pad(rst_line), .sys_rst_b_drv(drv), .sys_rst_b_oe(oe),
        .good_low_rail_pad(lo_pad), .good_low_rail_drv(lo_drv), .good_low_rail_oe(lo_oe),
        .good_high_rail_pad(hi_pad), .good_high_rail_drv(hi_drv), .good_high_rail_oe(hi_oe),
        .wd_trip_pulse(trip)
    );

    kick_host u_kick_host (
        .ref_clk(ref_clk), .rst_line(rst_line), .gap_cyc(gap), .wd_kick_in(kick)
    );

    task test_done;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task cyc(input int c);
        repeat (c) @(negedge ref_clk);
    endtask

    // Bounded wait for the reset line to be let go
    task rel(output int k);
        k = 0;
        while (oe !== 1'b0 && k < 2000) begin
            @(negedge ref_clk);
            k++;
        end
    endtask

    // Fresh start of the watchdog in a chosen mode and host spacing
    task arm(input logic [1:0] m, input logic [15:0] g);
        wt = m;
        gap = g;
        sense = 1'b0;
        cyc(20);
        sense = 1'b1;
        rel(n);
        t0 = trips;
    endtask

    task wd(input logic [1:0] m, input logic [15:0] g, input int span, input logic [31:0] exp);
        arm(m, g);
        cyc(span);
        chk(trips - t0, exp);
    endtask

    // Hang guard, well past the planned run
    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        test_done;
    end

    initial begin
        cyc(3);
        rst_b = 1'b1;
        chk(oe, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rt = i[1:0];
            sense = 1'b0;
            cyc(20);
            chk(oe, 1'b1);
            sense = 1'b1;
            rel(n);
            chk(n >= lims[i] + 12 && n <= lims[i] + 20, 1'b1);
            chk(drv, 1'b0);
            chk(rst_line, 1'b1);
        end
        rt = 2'h0;
        pump = 1'b0;
        cyc(20);
        chk(oe, 1'b1);
        pump = 1'b1;
        rel(n);
        sense = 1'b0;
        cyc(5);
        sense = 1'b1;
        cyc(10);
        chk(oe, 1'b0);
        cyc(20);
        chk(oe, 1'b0);
        uvlo = 1'b1;
        cyc(5);
        chk({oe, lo_oe, hi_oe}, 3'h7);
        cyc(200);
        chk(oe, 1'b1);
        uvlo = 1'b0;
        rel(n);
        chk(n >= lims[0], 1'b1);
        win_hi = 1'b0;
        cyc(5);
        chk({lo_oe, hi_oe}, 2'h1);
        chk({lo_pad, hi_pad}, 2'h2);
        win_hi = 1'b1;
        en_lo = 1'b0;
        en_hi = 1'b0;
        cyc(5);
        chk({lo_oe, hi_oe}, 2'h3);
        en_lo = 1'b1;
        en_hi = 1'b1;
        cyc(5);
        chk({lo_oe, hi_oe}, 2'h0);
        wd(2'h2, 16'd60, 1000, 0);
        wd(2'h2, 16'd9, 30, 1);
        wd(2'h2, 16'd21, 300, 0);
        wd(2'h2, 16'd0, 378, 0);
        cyc(14);
        chk(trips - t0, 1);
        rel(n);
        chk(n <= 30, 1'b1);
        t0 = trips;
        cyc(378);
        chk(trips - t0, 0);
        cyc(14);
        chk(trips - t0, 1);
        wd(2'h1, 16'd0, 16370, 0);
        cyc(30);
        chk(trips - t0, 1);
        wd(2'h1, 16'd500, 520, 1);
        wd(2'h1, 16'd540, 1700, 0);
        wd(2'h0, 16'd3, 500, 0);
        wd(2'h0, 16'd0, 500, 0);
        test_done;
    end
endmodule // test_reset_supervisor_windowed_watchdog
